/* hdl/lsw_ctrl.sv */
// bus sleep and wakeup controller with register slave
//
// Functional notes
// - slave awake, four seconds idle: flag, interrupt
// - any wakeup signal ends bus sleep (here a detected wakeup only sets flags; sleep_q clears only on a CTRL write)
// - wakeup request bit transmits wakeup signal
// - master: wakeup sent sets done, interrupt
// - slave: no interrupt for own sent wakeup
// - slave: no response in 150ms, timeout error
// - detected wakeup sets wakeup, done, interrupt
// - any error interrupts and aborts current frame
// - error reset bit clears error register, flag
// - wakeup or master frame refused while error
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "lsw_params.svh"
module lsw_ctrl #(
  parameter int ADDR_W = 8,
  parameter int unsigned IDLE_CYC =
    `LSW_IDLE_S * 1000000 * `LSW_CLK_MHZ,
  parameter int unsigned RESP_CYC =
    `LSW_RESP_MS * 1000 * `LSW_CLK_MHZ,
  parameter int unsigned WAKE_CYC = `LSW_WAKE_US * `LSW_CLK_MHZ,
  parameter int unsigned DET_CYC = `LSW_DET_US * `LSW_CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output lsw_pkg::lsw_resp_type s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output lsw_pkg::lsw_resp_type s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic lin_rx,
  output logic lin_tx_out,
  output logic lin_tx_oe,
  input wire logic frame_err,
  input wire logic frame_start_req,
  output logic frame_start_ok,
  output logic frame_abort,
  output logic irq
);
  import lsw_pkg::*;

  localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'(`LSW_OFS_CTRL);
  localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'(`LSW_OFS_STAT);
  localparam logic [ADDR_W-1:0] A_ERR = ADDR_W'(`LSW_OFS_ERR);
  localparam logic [ADDR_W-1:0] A_MASK = ADDR_W'(`LSW_OFS_MASK);
  localparam logic [ADDR_W-1:0] A_CFG = ADDR_W'(`LSW_OFS_CFG);

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == A_CTRL) | (a == A_STAT) | (a == A_ERR) |
      (a == A_MASK) | (a == A_CFG);
  endfunction : mapped

  // set wins over clear
  function automatic logic [7:0] sticky(input logic [7:0] q,
    input logic [7:0] clr, input logic [7:0] set);
    sticky = (q & ~clr) | set;
  endfunction : sticky

  // bus slave state
  logic aw_got_q;
  logic w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb_q;
  logic bvalid_q;
  lsw_resp_type bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  lsw_resp_type rresp_q;

  // block state
  logic sleep_q;
  logic master_q;
  logic [7:0] status_q;
  logic [7:0] err_q;
  logic [7:0] mask_q;
  lsw_state_type state_q;
  lsw_state_type state_d;
  logic tx_oe_q;
  logic abort_q;
  logic rx_s;
  logic rx_q;

  // write path decode
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_got_q & w_got_q & ~bvalid_q;
  wire wr_lo = wr_fire & wstrb_q;
  wire wr_ctrl = wr_lo & (awaddr_q == A_CTRL);
  wire wr_stat = wr_lo & (awaddr_q == A_STAT);
  wire wr_mask = wr_lo & (awaddr_q == A_MASK);
  wire wr_cfg = wr_lo & (awaddr_q == A_CFG);
  wire ar_fire = s_axi_arvalid & s_axi_arready;

  assign s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready = ~w_got_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // bus line sampling
  lsw_sync u_rx_sync (
    .clk(clk),
    .rst(rst),
    .d(lin_rx),
    .q(rx_s)
  );
  wire rx_edge = rx_s ^ rx_q;
  wire rx_fall = rx_q & ~rx_s;

  // events
  wire err_flag = status_q[`LSW_B_ERROR];
  wire in_idle = (state_q == ST_IDLE);
  wire in_send = (state_q == ST_SEND);
  wire in_wait = (state_q == ST_WAIT);
  wire wu_req_wr = wr_ctrl & wdata_q[`LSW_B_WUREQ];
  wire wu_start = wu_req_wr & ~err_flag & in_idle;
  wire clr_err = wr_ctrl & wdata_q[`LSW_B_ERRCLR];
  wire idle_ev;
  wire wake_sent;
  wire response_timeout_error_ev;
  wire det_ev;
  wire resp_seen = in_wait & rx_fall;
  wire err_ev = response_timeout_error_ev | frame_err;

  // idle watch only while awake as slave
  lsw_timer #(.LIMIT(IDLE_CYC)) u_idle (
    .clk(clk),
    .rst(rst),
    .run(~master_q & ~sleep_q),
    .clear(rx_edge | sleep_q | master_q),
    .hit(idle_ev)
  );

  // dominant wakeup pulse length
  lsw_timer #(.LIMIT(WAKE_CYC)) u_wake (
    .clk(clk),
    .rst(rst),
    .run(in_send),
    .clear(~in_send),
    .hit(wake_sent)
  );

  // slave wait for master answer
  lsw_timer #(.LIMIT(RESP_CYC)) u_resp (
    .clk(clk),
    .rst(rst),
    .run(in_wait),
    .clear(~in_wait | rx_fall),
    .hit(response_timeout_error_ev)
  );

  // wakeup detection from other nodes while asleep
  lsw_timer #(.LIMIT(DET_CYC)) u_det (
    .clk(clk),
    .rst(rst),
    .run(sleep_q & ~rx_s & in_idle),
    .clear(rx_s | ~sleep_q),
    .hit(det_ev)
  );

  // sticky status and error sets
  wire [7:0] stat_set = {1'b0, idle_ev, 3'h0, err_ev, det_ev,
    det_ev | (wake_sent & master_q)};
  wire [7:0] stat_clr = ({8{wr_stat}} & wdata_q) |
    {5'h00, clr_err, 2'h0};
  wire [7:0] err_set = {5'h00, response_timeout_error_ev, 1'b0, frame_err};
  wire [7:0] stat_d = sticky(status_q, stat_clr, stat_set) &
    `LSW_STICKY;
  wire [7:0] err_d = sticky(err_q, {8{clr_err}}, err_set);

  // wakeup sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (wu_start) begin
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (wake_sent) begin
          state_d = master_q ? ST_IDLE : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (resp_seen | response_timeout_error_ev) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // read word assembly
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`LSW_B_SLEEP] = sleep_q;
    ctrl_rd[`LSW_B_WUREQ] = ~in_idle;
    stat_rd = status_q;
    stat_rd[`LSW_B_ACTIVE] = ~in_idle;
  end
  wire [7:0] rd_byte =
    (s_axi_araddr == A_CTRL) ? ctrl_rd :
    (s_axi_araddr == A_STAT) ? stat_rd :
    (s_axi_araddr == A_ERR) ? err_q :
    (s_axi_araddr == A_MASK) ? mask_q :
    (s_axi_araddr == A_CFG) ? {7'h00, master_q} : 8'h00;

  assign lin_tx_out = 1'b0;
  assign lin_tx_oe = tx_oe_q;
  assign frame_abort = abort_q;
  assign frame_start_ok = frame_start_req & master_q & ~err_flag;
  assign irq = |(status_q & mask_q);

  // bus slave handshakes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `LSW_RESP_OK;
    end else begin
      if (aw_fire) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= mapped(awaddr_q) ? `LSW_RESP_OK : `LSW_RESP_SLVERR;
      end else if (bvalid_q & s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `LSW_RESP_OK;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= mapped(s_axi_araddr) ? `LSW_RESP_OK : `LSW_RESP_SLVERR;
    end else if (rvalid_q & s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_q <= 1'b0;
      master_q <= 1'b0;
      mask_q <= `LSW_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        sleep_q <= wdata_q[`LSW_B_SLEEP];
      end
      if (wr_cfg) begin
        master_q <= wdata_q[`LSW_B_MASTER];
      end
      if (wr_mask) begin
        mask_q <= wdata_q & `LSW_STICKY;
      end
    end
  end

  // status, error and sequencer state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= `LSW_STAT_RST;
      err_q <= `LSW_ERR_RST;
      state_q <= ST_IDLE;
      tx_oe_q <= 1'b0;
      abort_q <= 1'b0;
      rx_q <= 1'b1;
    end else begin
      status_q <= stat_d;
      err_q <= err_d;
      state_q <= state_d;
      tx_oe_q <= (state_d == ST_SEND);
      abort_q <= err_ev;
      rx_q <= rx_s;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_idle_slave_only: assert property (
    $rose(status_q[`LSW_B_IDLE]) |-> $past(!master_q && !sleep_q))
    else $error("idle flag rose while master or asleep");

  a_idle_held_asleep: assert property (
    sleep_q |-> !idle_ev)
    else $error("idle timeout counted while asleep");

  a_wake_drive: assert property (
    wu_start |=> lin_tx_oe [*8])
    else $error("wakeup request did not drive the bus");

  a_wake_refused: assert property (
    wu_req_wr && err_flag && in_idle |=> in_idle && !lin_tx_oe)
    else $error("wakeup started while error flag set");

  a_master_done: assert property (
    wake_sent && master_q |=> status_q[`LSW_B_DONE] && in_idle)
    else $error("master wakeup end did not set done");

  a_slave_quiet: assert property (
    wake_sent && !master_q && !status_q[`LSW_B_DONE]
    |=> !status_q[`LSW_B_DONE] && in_wait)
    else $error("slave wakeup end set done");

  a_resp_response_timeout_error: assert property (
    response_timeout_error_ev |=> status_q[`LSW_B_ERROR] && err_q[`LSW_B_RESPONSE_TIMEOUT_ERROR]
      && in_idle ##1 !lin_tx_oe)
    else $error("response timeout not flagged or retried");

  a_wake_seen: assert property (
    det_ev |=> status_q[`LSW_B_WAKE] && status_q[`LSW_B_DONE])
    else $error("detected wakeup not flagged");

  a_err_abort: assert property (
    err_ev |=> frame_abort && err_flag)
    else $error("error did not abort frame");

  a_err_clear: assert property (
    clr_err && !err_ev |=> !err_flag && err_q == 8'h00)
    else $error("error reset did not clear error state");

endmodule : lsw_ctrl

/* hdl/lsw_sync.sv */
// two flip-flop synchroniser for a pin level
`timescale 1ns/100ps
module lsw_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_q;
  logic q_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q_q <= RST_VAL;
    end else begin
      meta_q <= d;
      q_q <= meta_q;
    end
  end
  assign q = q_q;
endmodule : lsw_sync

/* hdl/lsw_timer.sv */
// saturating cycle timer with one-shot hit pulse
`timescale 1ns/100ps
module lsw_timer #(
  parameter int unsigned LIMIT = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic clear,
  output logic hit
);
  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic live;
  assign live = run & ~clear & (cnt_q <= LAST);
  assign hit = live & (cnt_q == LAST);
  assign cnt_d = clear ? '0 : (live ? cnt_q + 1'b1 : cnt_q);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : lsw_timer

/* shared/lsw_params.svh */
// register map, bit positions and timing figures
`ifndef LSW_PARAMS_SVH
`define LSW_PARAMS_SVH
`define LSW_CLK_MHZ 100
`define LSW_IDLE_S 4
`define LSW_RESP_MS 150
`define LSW_WAKE_US 250
`define LSW_DET_US 150
`define LSW_OFS_CTRL 8'h00
`define LSW_OFS_STAT 8'h04
`define LSW_OFS_ERR 8'h08
`define LSW_OFS_MASK 8'h0C
`define LSW_OFS_CFG 8'h10
`define LSW_B_SLEEP 6
`define LSW_B_ERRCLR 2
`define LSW_B_WUREQ 1
`define LSW_B_DONE 0
`define LSW_B_WAKE 1
`define LSW_B_ERROR 2
`define LSW_B_IDLE 6
`define LSW_B_ACTIVE 7
`define LSW_B_RESPONSE_TIMEOUT_ERROR 2
`define LSW_B_FERR 0
`define LSW_B_MASTER 0
`define LSW_STICKY 8'h47
`define LSW_STAT_RST 8'h00
`define LSW_MASK_RST 8'h00
`define LSW_ERR_RST 8'h00
`define LSW_RESP_OK 2'h0
`define LSW_RESP_SLVERR 2'h2
`endif

/* shared/lsw_pkg.sv */
// shared types for the sleep and wakeup controller
package lsw_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} lsw_state_type;
  typedef logic [1:0] lsw_resp_type;
endpackage : lsw_pkg

/* test/lin_sleep_wakeup_control_tb.sv */
// self-checking bench of the sleep and wakeup controller
`timescale 1ns/100ps
`include "lsw_params.svh"
module lin_sleep_wakeup_control_tb;
  import lsw_pkg::*;
  localparam int IDLE = 200;
  localparam int RESP = 100;
  localparam int WAKE = 10;
  logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, frame_err = 0, start_req = 0;
  logic respond = 0, wake_go = 0, oe_prev = 0;
  logic awready, wready, bvalid, arready, rvalid, lin_rx, tx_out;
  logic tx_oe, irq, start_ok, abort;
  logic [7:0] awaddr = 0, araddr = 0, stat_m = 0, mask_m = 0;
  logic [31:0] wdata = 0, rdata, rnd = 32'h9CB4;
  lsw_resp_type bresp, rresp;
  int fail_count = 0, checked = 0, rises = 0, n, r0, hi = 0, h0;

  always #5 clk = ~clk;
  always @(posedge clk) begin
    oe_prev <= tx_oe;
    if (tx_oe && !oe_prev) rises <= rises + 1;
    if (tx_oe) hi <= hi + 1;
  end

  lsw_ctrl #(.IDLE_CYC(IDLE), .RESP_CYC(RESP), .WAKE_CYC(WAKE),
    .DET_CYC(5)) u_lsw_ctrl (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .lin_rx(lin_rx), .lin_tx_out(tx_out),
    .lin_tx_oe(tx_oe), .frame_err(frame_err),
    .frame_start_req(start_req), .frame_start_ok(start_ok),
    .frame_abort(abort), .irq(irq));

  lsw_bus_node u_lsw_bus_node (.clk(clk), .rst(rst), .tx_oe(tx_oe),
    .respond(respond), .wake_go(wake_go), .lin_rx(lin_rx));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    rnd = lfsr(rnd);
    @(posedge clk);
    awaddr <= a;
    wdata <= {rnd[23:0], d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready) begin
        aw_done = 1;
        awvalid <= 0;
      end
      if (!w_done && wready) begin
        w_done = 1;
        wvalid <= 0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
    rready <= 0;
    check(rdata, {24'h0, e});
  endtask : rd

  task automatic stat_chk();
    rd(`LSW_OFS_STAT, stat_m);
    check(irq, |(stat_m & mask_m));
  endtask : stat_chk

  task automatic clr(input logic [7:0] v);
    wr(`LSW_OFS_STAT, v);
    stat_m = stat_m & ~v;
    stat_chk();
  endtask : clr

  task automatic send(input logic [7:0] d);
    h0 = hi;
    wr(`LSW_OFS_CTRL, d);
    repeat (30) @(posedge clk);
    n = hi - h0;
  endtask : send

  task automatic give_verdict();
    $display("checks %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    rd(`LSW_OFS_CTRL, 0);
    rd(`LSW_OFS_ERR, 0);
    rd(`LSW_OFS_MASK, 0);
    rd(`LSW_OFS_CFG, 0);
    rd(8'h14, 0);
    check(rresp, `LSW_RESP_SLVERR);
    wr(8'h14, 8'hFF);
    check(bresp, `LSW_RESP_SLVERR);
    mask_m = `LSW_STICKY;
    wr(`LSW_OFS_MASK, mask_m);
    repeat (IDLE + 20) @(posedge clk);
    stat_m = 8'h40;
    stat_chk();
    wr(`LSW_OFS_CTRL, 8'h40);
    clr(8'h40);
    repeat (IDLE + 20) @(posedge clk);
    stat_chk();
    wake_go <= 1;
    @(posedge clk);
    wake_go <= 0;
    repeat (40) @(posedge clk);
    stat_m = 8'h03;
    stat_chk();
    wr(`LSW_OFS_CTRL, 8'h00);
    clr(8'h03);
    wr(`LSW_OFS_CFG, 8'h01);
    send(8'h02);
    check(n, WAKE);
    check(tx_out, 0);
    stat_m = 8'h01;
    stat_chk();
    clr(8'h01);
    wr(`LSW_OFS_CFG, 8'h00);
    respond <= 1;
    send(8'h42);
    check(n, WAKE);
    repeat (20) @(posedge clk);
    stat_chk();
    respond <= 0;
    r0 = rises;
    send(8'h42);
    repeat (RESP + 20) @(posedge clk);
    stat_m = 8'h04;
    stat_chk();
    rd(`LSW_OFS_ERR, 8'h04);
    check(rises, r0 + 1);
    send(8'h42);
    check(n, 0);
    wr(`LSW_OFS_CFG, 8'h01);
    start_req <= 1;
    repeat (2) @(posedge clk);
    check(start_ok, 0);
    wr(`LSW_OFS_CTRL, 8'h04);
    stat_m = 8'h00;
    rd(`LSW_OFS_ERR, 0);
    stat_chk();
    check(start_ok, 1);
    start_req <= 0;
    frame_err <= 1;
    @(posedge clk);
    frame_err <= 0;
    n = 0;
    repeat (4) @(posedge clk) if (abort) n++;
    check(n, 1);
    stat_m = 8'h04;
    stat_chk();
    rd(`LSW_OFS_ERR, 8'h01);
    give_verdict();
  end
endmodule : lin_sleep_wakeup_control_tb

/* test/lsw_bus_node.sv */
// bus node model on the far side of the link
`timescale 1ns/100ps
module lsw_bus_node #(
  parameter int WAKE_LEN = 20,
  parameter int RESP_DLY = 20,
  parameter int RESP_LEN = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_oe,
  input wire logic respond,
  input wire logic wake_go,
  output logic lin_rx
);
  logic oe_q;
  int dly;
  int cnt;
  // pull-up gives recessive while nobody drives
  assign lin_rx = !(tx_oe || cnt != 0);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_q <= 1'b0;
      dly <= 0;
      cnt <= 0;
    end else begin
      oe_q <= tx_oe;
      if (dly == 1) cnt <= RESP_LEN;
      else if (cnt != 0) cnt <= cnt - 1;
      if (dly != 0) dly <= dly - 1;
      if (oe_q && !tx_oe && respond) dly <= RESP_DLY;
      if (wake_go) cnt <= WAKE_LEN;
    end
  end
endmodule : lsw_bus_node
